// ===== rtl/hw_irq_pkg.sv
// Constants for the hardware interrupt register triplet, bits 12 to 0
`default_nettype none
package hw_irq_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PENDING = 8'h06;
    localparam logic [7:0] ADDR_ENABLE = 8'h0F;
    localparam logic [7:0] ADDR_OUT_ENABLE = 8'h13;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_LB_FAIL_A = 12;
    localparam int BIT_LB_FAIL_B = 11;
    localparam int BIT_MT_ROLLOVER = 10;
    localparam int BIT_RT_MATCH = 7;
    localparam int BIT_MT_MATCH = 6;
    localparam int BIT_ALWAYS_ONE = 4;
    localparam int BIT_ADDR_PARITY = 3;
    localparam int BIT_RT_PENDING = 2;
    localparam int BIT_MT_PENDING = 1;
    // ------------------------------------------------------------
    // Masks and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] MASK_EVENTS = 16'h1CC0;
    localparam logic [15:0] MASK_OE_WRITE = 16'h1CC8;
    localparam logic [15:0] MASK_HOST_CLEAR = 16'h04C0;
    localparam logic [15:0] CONST_ONES = 16'h0010;
    localparam logic [15:0] ENABLE_FIXED = 16'h0018;
    localparam logic [15:0] RESET_ENABLE = 16'h0000;
    localparam logic [15:0] RESET_OUT_ENABLE = 16'h0008;
    localparam logic [15:0] RESET_PENDING = 16'h0008;
    localparam int RT_COUNT_W = 16;
    localparam int MT_SHORT_W = 16;
    localparam int MT_LONG_W = 48;
    localparam int ADDR_W = 5;
    localparam int SYNC_STAGES = 3;
    // ------------------------------------------------------------
    // Loopback checker states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LB_IDLE = 2'b00,
        LB_WAIT = 2'b01
    } lb_state_t;
endpackage
`default_nettype wire

// ===== rtl/hw_irq_triplet.sv
// Hardware interrupt enable, pending and output enable registers
`timescale 1ns/1ns
`default_nettype none
module hw_irq_triplet
    import hw_irq_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_master_reset_pin,
    input wire logic [ADDR_W-1:0] i_terminal_address,
    input wire logic i_terminal_address_parity,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_tx_word_done,
    input wire logic i_tx_bus_b,
    input wire logic i_tx_last_word,
    input wire logic [15:0] i_tx_data,
    input wire logic i_rx_word_valid,
    input wire logic i_rx_sync_ok,
    input wire logic i_rx_encoding_ok,
    input wire logic i_rx_bit_count_ok,
    input wire logic i_rx_parity_ok,
    input wire logic [15:0] i_rx_data,
    input wire logic i_rt_tick,
    input wire logic [RT_COUNT_W-1:0] i_rt_match,
    input wire logic i_mt_tick,
    input wire logic i_mt_long_count,
    input wire logic [MT_LONG_W-1:0] i_mt_match,
    input wire logic i_rt_pending_any,
    input wire logic i_mt_pending_any,
    output logic [15:0] o_reg_rdata,
    output logic o_irq_request,
    output logic [RT_COUNT_W-1:0] o_rt_count,
    output logic [MT_LONG_W-1:0] o_mt_count
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    function automatic logic [MT_LONG_W-1:0] mt_width_mask(input logic w);
        mt_width_mask = w ? {MT_LONG_W{1'b1}}
                          : {{(MT_LONG_W-MT_SHORT_W){1'b0}},
                             {MT_SHORT_W{1'b1}}};
    endfunction

    logic [15:0] enable_reg;
    logic [15:0] out_enable_reg;
    logic [15:0] pending_reg;
    logic [15:0] event_set;
    logic [15:0] rdata_next;
    logic pending_read;
    logic [SYNC_STAGES-1:0] pin_sync_reg;
    logic [ADDR_W:0] strap_sync1_reg;
    logic [ADDR_W:0] strap_sync2_reg;
    logic [ADDR_W:0] strap_sync3_reg;
    logic pin_level_reg;
    logic pin_rise;
    logic parity_fail_reg;
    lb_state_t lb_state_reg;
    logic lb_bus_b_reg;
    logic lb_last_reg;
    logic [15:0] lb_data_reg;
    logic lb_bad;
    logic lb_fail_a;
    logic lb_fail_b;
    logic [MT_LONG_W-1:0] mt_mask;
    logic [MT_LONG_W-1:0] mt_count_next;
    logic [RT_COUNT_W-1:0] rt_count_next;
    logic mt_wrap;
    logic mt_match;
    logic rt_match;

    assign pending_read = i_reg_rd && hit(i_reg_addr, ADDR_PENDING);

    // ------------------------------------------------------------
    // Master reset pin and strap synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_sync_reg <= '0;
            strap_sync1_reg <= '0;
            strap_sync2_reg <= '0;
            strap_sync3_reg <= '0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[SYNC_STAGES-2:0], i_master_reset_pin};
            strap_sync1_reg <= {i_terminal_address_parity, i_terminal_address};
            strap_sync2_reg <= strap_sync1_reg;
            strap_sync3_reg <= strap_sync2_reg;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_level_reg <= 1'b0;
        end else if (pin_sync_reg[1] == pin_sync_reg[2]) begin
            pin_level_reg <= pin_sync_reg[2];
        end
    end

    assign pin_rise = (pin_sync_reg[1] == pin_sync_reg[2]) && pin_sync_reg[2]
                      && !pin_level_reg;

    // Odd number of ones required across address and parity
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            parity_fail_reg <= 1'b1;
        end else if (pin_rise) begin
            parity_fail_reg <= ~(^strap_sync3_reg);
        end
    end

    // ------------------------------------------------------------
    // Loopback checker
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lb_state_reg <= LB_IDLE;
            lb_bus_b_reg <= 1'b0;
            lb_last_reg <= 1'b0;
            lb_data_reg <= '0;
        end else begin
            case (lb_state_reg)
                LB_IDLE: begin
                    if (i_tx_word_done) begin
                        lb_state_reg <= LB_WAIT;
                    end
                end
                LB_WAIT: begin
                    if (i_rx_word_valid && !i_tx_word_done) begin
                        lb_state_reg <= LB_IDLE;
                    end
                end
                default: begin
                    lb_state_reg <= LB_IDLE;
                end
            endcase
            if (i_tx_word_done) begin
                lb_bus_b_reg <= i_tx_bus_b;
                lb_last_reg <= i_tx_last_word;
                lb_data_reg <= i_tx_data;
            end
        end
    end

    assign lb_bad = !(i_rx_sync_ok && i_rx_encoding_ok && i_rx_bit_count_ok
                      && i_rx_parity_ok)
                    || (lb_last_reg && (i_rx_data != lb_data_reg));
    assign lb_fail_a = (lb_state_reg == LB_WAIT) && i_rx_word_valid
                       && lb_bad && !lb_bus_b_reg;
    assign lb_fail_b = (lb_state_reg == LB_WAIT) && i_rx_word_valid
                       && lb_bad && lb_bus_b_reg;

    // ------------------------------------------------------------
    // Time-tag counters
    // ------------------------------------------------------------
    assign mt_mask = mt_width_mask(i_mt_long_count);
    assign mt_wrap = i_mt_tick && ((o_mt_count & mt_mask) == mt_mask);
    assign mt_count_next = (o_mt_count + 1'b1) & mt_mask;
    assign mt_match = i_mt_tick
                      && (mt_count_next == (i_mt_match & mt_mask));
    assign rt_count_next = o_rt_count + 1'b1;
    assign rt_match = i_rt_tick && (rt_count_next == i_rt_match);

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_mt_count <= '0;
        end else if (i_mt_tick) begin
            o_mt_count <= mt_count_next;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rt_count <= '0;
        end else if (i_rt_tick) begin
            o_rt_count <= rt_count_next;
        end
    end

    // ------------------------------------------------------------
    // Enable and output enable registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            enable_reg <= RESET_ENABLE;
        end else if (i_reg_wr && hit(i_reg_addr, ADDR_ENABLE)) begin
            enable_reg <= i_reg_wdata & MASK_EVENTS;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            out_enable_reg <= RESET_OUT_ENABLE;
        end else if (i_reg_wr && hit(i_reg_addr, ADDR_OUT_ENABLE)) begin
            out_enable_reg <= i_reg_wdata & MASK_OE_WRITE;
        end
    end

    // ------------------------------------------------------------
    // Pending register
    // ------------------------------------------------------------
    always_comb begin
        event_set = '0;
        event_set[BIT_LB_FAIL_A] = lb_fail_a;
        event_set[BIT_LB_FAIL_B] = lb_fail_b;
        event_set[BIT_MT_ROLLOVER] = mt_wrap;
        event_set[BIT_RT_MATCH] = rt_match;
        event_set[BIT_MT_MATCH] = mt_match;
        event_set = event_set & enable_reg;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pending_reg <= RESET_PENDING;
        end else begin
            // Set wins over read clear and host write clear
            if (pending_read) begin
                pending_reg[BIT_LB_FAIL_A] <= event_set[BIT_LB_FAIL_A];
                pending_reg[BIT_LB_FAIL_B] <= event_set[BIT_LB_FAIL_B];
            end else begin
                pending_reg[BIT_LB_FAIL_A] <= pending_reg[BIT_LB_FAIL_A]
                                              | event_set[BIT_LB_FAIL_A];
                pending_reg[BIT_LB_FAIL_B] <= pending_reg[BIT_LB_FAIL_B]
                                              | event_set[BIT_LB_FAIL_B];
            end
            if (i_reg_wr && hit(i_reg_addr, ADDR_PENDING)) begin
                pending_reg[BIT_MT_ROLLOVER] <= event_set[BIT_MT_ROLLOVER]
                    | (pending_reg[BIT_MT_ROLLOVER]
                       & ~i_reg_wdata[BIT_MT_ROLLOVER]);
                pending_reg[BIT_RT_MATCH] <= event_set[BIT_RT_MATCH]
                    | (pending_reg[BIT_RT_MATCH] & ~i_reg_wdata[BIT_RT_MATCH]);
                pending_reg[BIT_MT_MATCH] <= event_set[BIT_MT_MATCH]
                    | (pending_reg[BIT_MT_MATCH] & ~i_reg_wdata[BIT_MT_MATCH]);
            end else begin
                pending_reg[BIT_MT_ROLLOVER] <= pending_reg[BIT_MT_ROLLOVER]
                                                | event_set[BIT_MT_ROLLOVER];
                pending_reg[BIT_RT_MATCH] <= pending_reg[BIT_RT_MATCH]
                                             | event_set[BIT_RT_MATCH];
                pending_reg[BIT_MT_MATCH] <= pending_reg[BIT_MT_MATCH]
                                             | event_set[BIT_MT_MATCH];
            end
            pending_reg[BIT_ADDR_PARITY] <= parity_fail_reg;
            pending_reg[BIT_RT_PENDING] <= i_rt_pending_any;
            pending_reg[BIT_MT_PENDING] <= i_mt_pending_any;
        end
    end

    // ------------------------------------------------------------
    // Read path and interrupt request
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = o_reg_rdata;
        if (i_reg_rd) begin
            if (hit(i_reg_addr, ADDR_PENDING)) begin
                rdata_next = pending_reg | CONST_ONES;
            end else if (hit(i_reg_addr, ADDR_ENABLE)) begin
                rdata_next = enable_reg | ENABLE_FIXED;
            end else if (hit(i_reg_addr, ADDR_OUT_ENABLE)) begin
                rdata_next = out_enable_reg | CONST_ONES;
            end else begin
                rdata_next = '0;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata <= '0;
        end else begin
            o_reg_rdata <= rdata_next;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq_request <= 1'b0;
        end else begin
            o_irq_request <= |(pending_reg & (enable_reg | ENABLE_FIXED)
                               & out_enable_reg & ~CONST_ONES);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_lb_a_sets: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        lb_fail_a && enable_reg[BIT_LB_FAIL_A] |=> pending_reg[BIT_LB_FAIL_A])
        else $error("bus A loopback failure not flagged");
    chk_lb_b_sets: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        lb_fail_b && enable_reg[BIT_LB_FAIL_B] |=> pending_reg[BIT_LB_FAIL_B])
        else $error("bus B loopback failure not flagged");
    chk_lb_persist: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        pending_reg[BIT_LB_FAIL_A] && !pending_read
        |=> pending_reg[BIT_LB_FAIL_A])
        else $error("loopback flag dropped without read");
    chk_lb_read_clear: assert property (@(posedge i_sys_clk)
        disable iff (!i_rstn)
        pending_read && !lb_fail_a |=> !pending_reg[BIT_LB_FAIL_A])
        else $error("loopback flag not cleared by read");
    chk_mt_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        mt_wrap && enable_reg[BIT_MT_ROLLOVER]
        |=> pending_reg[BIT_MT_ROLLOVER] && ((o_mt_count & mt_mask) == '0))
        else $error("monitor rollover missed");
    chk_rt_match: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        rt_match && enable_reg[BIT_RT_MATCH]
        |=> pending_reg[BIT_RT_MATCH] && o_rt_count == $past(i_rt_match))
        else $error("RT time-tag match missed");
    chk_gate_enable: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        !enable_reg[BIT_MT_MATCH] && !pending_reg[BIT_MT_MATCH]
        |=> !pending_reg[BIT_MT_MATCH])
        else $error("disabled event set pending");
    chk_low_bits: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        $past(i_reg_rd) && !hit($past(i_reg_addr), ADDR_PENDING)
        |-> o_reg_rdata[2:0] == 3'h0 && !o_reg_rdata[9] && !o_reg_rdata[0])
        else $error("reserved low bits not zero");
    chk_rt_pending: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_rt_pending_any ##1 i_reg_rd && hit(i_reg_addr, ADDR_PENDING)
        |=> o_reg_rdata[BIT_RT_PENDING])
        else $error("RT pending summary wrong");
    chk_mt_pending: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_mt_pending_any ##1 i_reg_rd && hit(i_reg_addr, ADDR_PENDING)
        |=> o_reg_rdata[BIT_MT_PENDING])
        else $error("MT pending summary wrong");
    chk_bit4_one: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        $past(i_reg_rd) && hit($past(i_reg_addr), ADDR_ENABLE)
        |-> o_reg_rdata[BIT_ALWAYS_ONE] && o_reg_rdata[BIT_ADDR_PARITY])
        else $error("enable fixed bits wrong");
endmodule
`default_nettype wire

// ===== verif/reg_host.sv
// Host model driving the register port of the interrupt triplet
`timescale 1ns/1ns
`default_nettype none
module reg_host (
    input wire logic i_sys_clk,
    input wire logic [15:0] i_reg_rdata,
    output logic [7:0] o_reg_addr,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [15:0] o_reg_wdata
);
    initial begin
        o_reg_addr = 8'h00;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_wdata = 16'h0000;
    end
    // Single word write, released data shows its inverse
    task automatic write(input logic [7:0] a, input logic [15:0] d);
        @(negedge i_sys_clk);
        o_reg_addr = a;
        o_reg_wdata = d;
        o_reg_wr = 1'b1;
        @(negedge i_sys_clk);
        o_reg_wr = 1'b0;
        o_reg_wdata = ~d;
    endtask
    // Single word read, data taken half a cycle after the read edge
    task automatic read(input logic [7:0] a, output logic [15:0] d);
        @(negedge i_sys_clk);
        o_reg_addr = a;
        o_reg_rd = 1'b1;
        @(negedge i_sys_clk);
        o_reg_rd = 1'b0;
        o_reg_addr = ~a;
        d = i_reg_rdata;
    endtask
endmodule
`default_nettype wire

// ===== verif/hw_interrupt_triplet_low_bits_bench.sv
// Self-checking bench for the interrupt triplet, bits 12 to 0
`timescale 1ns/1ns
`default_nettype none
module hw_interrupt_triplet_low_bits_bench;
    import hw_irq_pkg::*;
    logic sys_clk, rstn, master_pin, ta_par, tx_done, tx_b, tx_last, rx_v;
    logic rt_tick, mt_tick, mt_long, rt_pa, mt_pa, irq, wr, rd;
    logic [3:0] rx_ok;
    logic [4:0] ta;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, tx_d, rx_d, rt_m, rt_cnt;
    logic [47:0] mt_m, mt_cnt;
    int n_fail, samples_checked, en, oe, pnd, rtc, mtc;
    bit rtp, mtp;
    hw_irq_triplet dut (.i_sys_clk(sys_clk), .i_rstn(rstn),
        .i_master_reset_pin(master_pin), .i_terminal_address(ta),
        .i_terminal_address_parity(ta_par), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
        .i_tx_word_done(tx_done), .i_tx_bus_b(tx_b),
        .i_tx_last_word(tx_last), .i_tx_data(tx_d),
        .i_rx_word_valid(rx_v), .i_rx_sync_ok(rx_ok[3]),
        .i_rx_encoding_ok(rx_ok[2]), .i_rx_bit_count_ok(rx_ok[1]),
        .i_rx_parity_ok(rx_ok[0]), .i_rx_data(rx_d),
        .i_rt_tick(rt_tick), .i_rt_match(rt_m), .i_mt_tick(mt_tick),
        .i_mt_long_count(mt_long), .i_mt_match(mt_m),
        .i_rt_pending_any(rt_pa), .i_mt_pending_any(mt_pa),
        .o_reg_rdata(rdata), .o_irq_request(irq), .o_rt_count(rt_cnt),
        .o_mt_count(mt_cnt));
    reg_host host (.i_sys_clk(sys_clk), .i_reg_rdata(rdata),
        .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd),
        .o_reg_wdata(wdata));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #900000;
        n_fail++;
        close_out();
    end
    // ------------------------------------------------------------
    // Helpers and reference model
    // ------------------------------------------------------------
    task automatic close_out();
        $display("Checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [47:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        host.read(a, d);
        check("rdata", d, e);
    endtask
    task automatic rpend();
        rchk(8'h06, 16'(pnd) | 16'h0010 | {13'h0000, rtp, mtp, 1'b0});
        pnd = pnd & 32'hE7FF;
    endtask
    task automatic ev(input int b);
        if (en[b]) pnd[b] = 1'b1;
    endtask
    task automatic ticks(input bit mt, input int n);
        @(negedge sys_clk);
        if (mt) mt_tick = 1'b1; else rt_tick = 1'b1;
        repeat (n) @(negedge sys_clk);
        mt_tick = 1'b0;
        rt_tick = 1'b0;
        repeat (n) begin
            if (mt) begin
                if (mtc == 32'hFFFF && !mt_long) ev(10);
                mtc = (mtc + 1) & 32'hFFFF;
                if (mtc == mt_m[15:0] && !(mt_long && |mt_m[47:16])) begin
                    ev(6);
                end
            end else begin
                rtc = (rtc + 1) & 32'hFFFF;
                if (rtc == rt_m) ev(7);
            end
        end
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic lb(input bit b, l, input logic [3:0] ok, input bit mm);
        logic [15:0] d;
        d = 16'($urandom);
        @(negedge sys_clk);
        tx_done = 1'b1;
        tx_b = b;
        tx_last = l;
        tx_d = d;
        @(negedge sys_clk);
        tx_done = 1'b0;
        tx_d = ~d;
        rx_v = 1'b1;
        rx_ok = ok;
        rx_d = mm ? ~d : d;
        @(negedge sys_clk);
        rx_v = 1'b0;
        rx_ok = ~ok;
        rx_d = ~rx_d;
        if (ok != 4'hF || (l && mm)) ev(b ? 11 : 12);
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic straps(input logic [4:0] a, input logic p);
        @(negedge sys_clk);
        master_pin = 1'b0;
        ta = a;
        ta_par = p;
        repeat (6) @(negedge sys_clk);
        master_pin = 1'b1;
        repeat (8) @(negedge sys_clk);
        pnd[3] = ~^{a, p};
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h5730e9e1));
        {rstn, master_pin, ta_par, tx_done, tx_b, tx_last, rx_v} = 7'h00;
        {rt_tick, mt_tick, mt_long, rt_pa, mt_pa, rtp, mtp} = 7'h00;
        {rx_ok, ta, tx_d, rx_d, rt_m, mt_m} = 105'h0;
        {n_fail, samples_checked, en, rtc, mtc} = 160'h0;
        oe = 32'h0008;
        pnd = 32'h0008;
        repeat (6) @(negedge sys_clk);
        rstn = 1'b1;
        rpend();
        rchk(8'h0F, 16'h0018);
        rchk(8'h13, 16'h0018);
        rchk(8'h00, 16'h0000);
        check("irq", irq, 1'b1);
        $display("Test reset values done");
        rt_m = 16'h0003;
        ticks(0, 3);
        rpend();
        check("rt_count", rt_cnt, 48'(rtc));
        repeat (3) begin
            straps(5'($urandom), 1'($urandom));
            rpend();
        end
        straps(5'h01, 1'b0);
        rpend();
        check("irq", irq, 1'b0);
        $display("Test strap parity done");
        host.write(8'h0F, 16'hFFFF);
        en = 32'h1CC0;
        host.write(8'h13, 16'hFFFF);
        oe = 32'h1CC8;
        rchk(8'h0F, 16'h1CD8);
        rchk(8'h13, 16'(oe) | 16'h0010);
        host.write(8'h13, 16'h0000);
        oe = 0;
        rchk(8'h13, 16'(oe) | 16'h0010);
        host.write(8'h06, 16'hFFFF);
        rpend();
        $display("Test register access done");
        for (int i = 0; i < 8; i++) begin
            lb(i[0], i[1], i < 4 ? ~(4'h1 << i) : 4'hF, i[2] && i != 6);
            rpend();
        end
        lb(0, 0, 4'h7, 0);
        lb(0, 1, 4'hF, 0);
        rpend();
        rpend();
        check("irq", irq, 1'b0);
        host.write(8'h13, 16'hFFFF);
        lb(1, 0, 4'hB, 0);
        check("irq", irq, 1'b1);
        rpend();
        repeat (2) @(negedge sys_clk);
        check("irq", irq, 1'b0);
        $display("Test loopback done");
        rt_m = 16'(rtc + 1 + ($urandom % 8));
        ticks(0, 8);
        rpend();
        check("rt_count", rt_cnt, 48'(rtc));
        host.write(8'h06, 16'h0080);
        pnd = pnd & 32'hFF7F;
        rpend();
        $display("Test terminal match done");
        mt_m = {32'($urandom), 16'h0005};
        ticks(1, 5);
        rpend();
        host.write(8'h06, 16'h0040);
        pnd = pnd & 32'hFFBF;
        mt_long = 1'b1;
        mt_m[15:0] = 16'h0006;
        ticks(1, 1);
        rpend();
        check("mt_count", mt_cnt, 48'(mtc));
        mt_long = 1'b0;
        ticks(1, 65529);
        rpend();
        check("mt_count", mt_cnt, 48'(mtc));
        ticks(1, 1);
        rpend();
        check("mt_count", mt_cnt, 48'(mtc));
        $display("Test monitor count done");
        rt_pa = 1'b1;
        rtp = 1'b1;
        repeat (3) @(negedge sys_clk);
        rpend();
        rt_pa = 1'b0;
        mt_pa = 1'b1;
        rtp = 1'b0;
        mtp = 1'b1;
        repeat (3) @(negedge sys_clk);
        rpend();
        $display("Test pending summary done");
        close_out();
    end
endmodule
`default_nettype wire
